// ### hw/vpt_defs.svh
// Constants of the valve position teach and feedback block
`ifndef VPT_DEFS_SVH
`define VPT_DEFS_SVH

// ----------------------------------------------------------------
// Widths
// ----------------------------------------------------------------
`define VPT_DW 16
`define VPT_AW 4

// ----------------------------------------------------------------
// Stroke range (stroke_in counts 0.01 mm per LSB)
// ----------------------------------------------------------------
`define VPT_STROKE_MAX_MM 80
`define VPT_STROKE_LSB_PER_MM 100
`define VPT_STROKE_MAX_LSB (`VPT_STROKE_MAX_MM * `VPT_STROKE_LSB_PER_MM)
`define VPT_TOL_RST 16'h0032

// ----------------------------------------------------------------
// Timing, in milliseconds, and the cycle conversion
// ----------------------------------------------------------------
`define VPT_CLK_MHZ 200
`define VPT_TEACH_HOLD_MS 1500
`define VPT_RESET_HOLD_MS 2500
`define VPT_FAST_HALF_MS 100
`define VPT_SLOW_HALF_MS 400
`define VPT_MS_TO_CYC(ms) ((ms) * `VPT_CLK_MHZ * 1000)
`define VPT_FLASH_HALVES 3'h6

// ----------------------------------------------------------------
// Register word addresses
// ----------------------------------------------------------------
`define VPT_A_CTRL 4'h0
`define VPT_A_POS1 4'h1
`define VPT_A_POS2 4'h2
`define VPT_A_POS3 4'h3
`define VPT_A_TOL 4'h4
`define VPT_A_STROKE 4'h5
`define VPT_A_STAT 4'h6
`define VPT_A_IRQ_STS 4'h7
`define VPT_A_IRQ_EN 4'h8
`define VPT_A_IRQ_CLR 4'h9

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define VPT_CTRL_EXT 0
`define VPT_EV_TAUGHT 0
`define VPT_EV_TFAULT 1
`define VPT_EV_TRESET 2
`define VPT_EV_RANGE 3

`endif

// ### hw/vpt_pkg.sv
// Types of the valve position teach and feedback block
package vpt_pkg;

`include "vpt_defs.svh"

  // ----------------------------------------------------------------
  // Teach sequencer states
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    VPT_ST_IDLE = 2'b00,
    VPT_ST_FLASH = 2'b01,
    VPT_ST_CLR = 2'b10
  } vpt_state_t;

  // ----------------------------------------------------------------
  // Whole state of the core and of a hold detector
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [4:0] pin_m;
    logic [4:0] pin_s;
    logic ext_mode;
    logic [15:0] tol;
    logic [2:0][15:0] pos;
    logic [2:0] taught;
    logic in_range;
    logic [2:0] fb;
    vpt_state_t st;
    logic [1:0] tidx;
    logic tfault;
    logic [2:0] hcnt;
    logic [31:0] fdiv;
    logic fast_ph;
    logic [31:0] sdiv;
    logic slow_ph;
    logic [2:0] led_pos;
    logic [2:0] led_fault;
    logic ext1_out;
    logic [3:0] fb_dout;
    logic [2:0] valve;
    logic [3:0] irq_sts;
    logic [3:0] irq_en;
    logic [15:0] rdata;
    logic irq;
  } vpt_core_t;

  typedef struct packed {
    logic [31:0] cnt;
    logic fire;
  } vpt_hold_t;

endpackage : vpt_pkg

// ### hw/vpt_hold_det.sv
// Hold-time detector: one pulse after a request has stood long enough
module vpt_hold_det import vpt_pkg::*; #(
  parameter logic [31:0] LIMIT = 32'h0000_0010
) (
  input wire logic core_clk, // 200 MHz clock
  input wire logic sys_rst, // Async reset, active high
  input wire logic req, // Synchronised request level
  output logic fire // One-cycle pulse when hold time reached
);

  vpt_hold_t q;
  vpt_hold_t nxt;

  // ----------------------------------------------------------------
  // Counter saturates at the limit, so one hold gives one pulse
  // ----------------------------------------------------------------
  always_comb begin
    nxt = q;
    nxt.fire = 1'b0;
    if (!req) begin
      nxt.cnt = 32'h0000_0000; // Early release drops the count
    end else if (q.cnt != LIMIT) begin
      nxt.cnt = q.cnt + 32'h0000_0001;
      nxt.fire = (q.cnt == LIMIT - 32'h0000_0001);
    end
  end

  // State register
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      q <= '0;
    end else begin
      q <= nxt;
    end
  end

  assign fire = q.fire;

endmodule : vpt_hold_det

// ### hw/vpt_teach_fb.sv
// Valve position teach and feedback core with register port
//
// Added by the designer: the register addresses and the address-and-strobe port.
`include "vpt_defs.svh"
module vpt_teach_fb import vpt_pkg::*; #(
  parameter logic [31:0] TEACH_HOLD_CYC = `VPT_MS_TO_CYC(`VPT_TEACH_HOLD_MS),
  parameter logic [31:0] RESET_HOLD_CYC = `VPT_MS_TO_CYC(`VPT_RESET_HOLD_MS),
  parameter logic [31:0] FAST_HALF_CYC = `VPT_MS_TO_CYC(`VPT_FAST_HALF_MS),
  parameter logic [31:0] SLOW_HALF_CYC = `VPT_MS_TO_CYC(`VPT_SLOW_HALF_MS)
) (
  input wire logic core_clk, // 200 MHz clock
  input wire logic sys_rst, // Async reset, active high
  input wire logic [15:0] stroke_in, // Stroke, 0.01 mm per LSB, core clock
  input wire logic teach_btn_lower, // Teach button 1 pin, high pressed
  input wire logic teach_btn_upper, // Teach button 2 pin, high pressed
  input wire logic teach_btn_middle, // Teach button 3 pin, high pressed
  input wire logic ext_switch1_in, // External initiator 1 pin
  input wire logic ext_switch2_in, // External initiator 2 pin
  output logic pos1_feedback_out, // Position 1 reached
  output logic pos2_feedback_out, // Position 2 reached
  output logic pos3_feedback_out, // Position 3 reached
  output logic ext_switch1_out, // External initiator 1 relayed
  output logic [2:0] led_pos, // Position LEDs, normal colour
  output logic [2:0] led_fault, // Position LEDs, fault colour
  input wire logic [3:0] fb_data_in, // Data word from fieldbus master
  output logic [3:0] fb_data_out, // Data word to fieldbus master
  output logic [2:0] valve_drive, // Solenoid valves 1 to 3
  input wire logic [3:0] reg_addr, // Register word address
  input wire logic [15:0] reg_wdata, // Register write data
  input wire logic reg_wr, // Write strobe
  input wire logic reg_rd, // Read strobe
  output logic [15:0] reg_rdata, // Read data, cycle after strobe
  output logic irq // Level interrupt
);

  vpt_core_t q;
  vpt_core_t nxt;
  logic [2:0] btn_s;
  logic [1:0] ext_s;
  logic [2:0] teach_req;
  logic [2:0] teach_fire;
  logic clr_fire;
  logic fast_wrap;
  logic slow_wrap;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // Within tolerance of a stored switching position
  function automatic logic vpt_near(input logic [15:0] a, input logic [15:0] b,
                                    input logic [15:0] tol);
    logic [15:0] d;
    d = (a >= b) ? (a - b) : (b - a);
    return d <= tol;
  endfunction : vpt_near

  // Read mux; unmapped and write-only words read as zero
  function automatic logic [15:0] vpt_rd(input vpt_core_t s, input logic [3:0] a,
                                         input logic [15:0] stroke);
    logic [15:0] r;
    r = 16'h0000;
    case (a)
      `VPT_A_CTRL: r = {15'h0000, s.ext_mode};
      `VPT_A_POS1: r = s.pos[0];
      `VPT_A_POS2: r = s.pos[1];
      `VPT_A_POS3: r = s.pos[2];
      `VPT_A_TOL: r = s.tol;
      `VPT_A_STROKE: r = stroke;
      `VPT_A_STAT: r = {7'h00, s.st, s.in_range, s.fb, s.taught};
      `VPT_A_IRQ_STS: r = {12'h000, s.irq_sts};
      `VPT_A_IRQ_EN: r = {12'h000, s.irq_en};
      default: r = 16'h0000;
    endcase
    return r;
  endfunction : vpt_rd

  // ----------------------------------------------------------------
  // Synchronised pins and blink dividers
  // ----------------------------------------------------------------
  assign btn_s = q.pin_s[2:0];
  assign ext_s = q.pin_s[4:3];
  assign fast_wrap = (q.fdiv == FAST_HALF_CYC - 32'h0000_0001);
  assign slow_wrap = (q.sdiv == SLOW_HALF_CYC - 32'h0000_0001);

  // ----------------------------------------------------------------
  // Hold detectors: a lone button teaches, buttons 1+2 clear
  // ----------------------------------------------------------------
  // Exclusive requests so the clear combo never teaches on the way
  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++) begin : g_teach
      assign teach_req[gi] = btn_s[gi] && (btn_s == (3'h1 << gi));
      vpt_hold_det #(
        .LIMIT(TEACH_HOLD_CYC)
      ) u_hold (
        .core_clk(core_clk),
        .sys_rst(sys_rst),
        .req(teach_req[gi]),
        .fire(teach_fire[gi])
      );
    end
  endgenerate

  vpt_hold_det #(
    .LIMIT(RESET_HOLD_CYC)
  ) u_clr_hold (
    .core_clk(core_clk),
    .sys_rst(sys_rst),
    .req(btn_s == 3'h3),
    .fire(clr_fire)
  );

  // ----------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------
  always_comb begin
    logic [2:0] hit;
    logic [3:0] ev;
    logic [1:0] idx;
    hit = 3'h0;
    ev = 4'h0;
    idx = 2'h0;
    nxt = q;
    // Pins pass two flops before use
    nxt.pin_m = {ext_switch2_in, ext_switch1_in, teach_btn_middle, teach_btn_upper,
                 teach_btn_lower};
    nxt.pin_s = q.pin_m;

    // Free-running blink phases
    nxt.fdiv = fast_wrap ? 32'h0000_0000 : q.fdiv + 32'h0000_0001;
    nxt.fast_ph = fast_wrap ? !q.fast_ph : q.fast_ph;
    nxt.sdiv = slow_wrap ? 32'h0000_0000 : q.sdiv + 32'h0000_0001;
    nxt.slow_ph = slow_wrap ? !q.slow_ph : q.slow_ph;

    // Range check and position compare
    nxt.in_range = (stroke_in <= 16'(`VPT_STROKE_MAX_LSB));
    for (int i = 0; i < 3; i++) begin
      hit[i] = q.taught[i] && nxt.in_range && vpt_near(stroke_in, q.pos[i], q.tol);
    end
    if (q.ext_mode) begin
      nxt.fb = {1'b0, ext_s[1], ext_s[0]};
    end else begin
      nxt.fb = hit;
    end
    if (q.in_range && !nxt.in_range) begin
      ev[`VPT_EV_RANGE] = 1'b1;
    end

    // External initiator relay and fieldbus word
    nxt.ext1_out = ext_s[0];
    nxt.fb_dout = {2'b00, ext_s[1], ext_s[0]};
    nxt.valve = fb_data_in[2:0];

    // Teach sequencer; ignores buttons in the initiator variant
    case (q.st)
      VPT_ST_IDLE: begin
        if (clr_fire && !q.ext_mode) begin
          nxt.taught = 3'h0;
          nxt.st = VPT_ST_CLR;
          nxt.hcnt = 3'h0;
          ev[`VPT_EV_TRESET] = 1'b1;
        end else if ((|teach_fire) && !q.ext_mode) begin
          idx = teach_fire[2] ? 2'h2 : (teach_fire[1] ? 2'h1 : 2'h0);
          nxt.tidx = idx;
          nxt.hcnt = 3'h0;
          nxt.st = VPT_ST_FLASH;
          if (nxt.in_range) begin
            nxt.pos[idx] = stroke_in;
            nxt.taught[idx] = 1'b1;
            nxt.tfault = 1'b0;
            ev[`VPT_EV_TAUGHT] = 1'b1;
          end else begin
            nxt.tfault = 1'b1;
            ev[`VPT_EV_TFAULT] = 1'b1;
          end
        end
      end
      VPT_ST_FLASH, VPT_ST_CLR: begin
        // Six fast half periods give three flashes
        if (fast_wrap) begin
          nxt.hcnt = q.hcnt + 3'h1;
          if (q.hcnt == `VPT_FLASH_HALVES - 3'h1) begin
            nxt.st = VPT_ST_IDLE;
          end
        end
      end
      default: begin
        nxt.st = VPT_ST_IDLE;
      end
    endcase

    // LED drive from current state
    nxt.led_pos = 3'h0;
    nxt.led_fault = 3'h0;
    case (q.st)
      VPT_ST_FLASH: begin
        if (q.tfault) begin
          nxt.led_fault[2] = !q.hcnt[0];
        end else begin
          nxt.led_pos[q.tidx] = !q.hcnt[0];
        end
      end
      VPT_ST_CLR: begin
        nxt.led_fault = {3{!q.hcnt[0]}};
      end
      default: begin
        if (q.ext_mode) begin
          nxt.led_pos = {1'b0, q.fb[1:0]};
        end else if (q.in_range) begin
          nxt.led_pos[1:0] = q.fb[1:0];
          nxt.led_pos[2] = q.fb[2] && q.slow_ph;
          // Untaught slots blink in fault colour, only while in range
          nxt.led_fault = ~q.taught & {3{q.slow_ph}};
        end
      end
    endcase

    // Register writes; a host write after a teach in one cycle wins
    if (reg_wr) begin
      case (reg_addr)
        `VPT_A_CTRL: nxt.ext_mode = reg_wdata[`VPT_CTRL_EXT];
        `VPT_A_POS1: begin
          nxt.pos[0] = reg_wdata;
          nxt.taught[0] = 1'b1;
        end
        `VPT_A_POS2: begin
          nxt.pos[1] = reg_wdata;
          nxt.taught[1] = 1'b1;
        end
        `VPT_A_POS3: begin
          nxt.pos[2] = reg_wdata;
          nxt.taught[2] = 1'b1;
        end
        `VPT_A_TOL: nxt.tol = reg_wdata;
        `VPT_A_IRQ_EN: nxt.irq_en = reg_wdata[3:0];
        `VPT_A_IRQ_CLR: nxt.irq_sts = q.irq_sts & ~reg_wdata[3:0];
        default: nxt.irq_en = q.irq_en;
      endcase
    end
    // Set beats clear so no event is lost
    nxt.irq_sts = nxt.irq_sts | ev;
    nxt.irq = |(nxt.irq_sts & nxt.irq_en);

    // Read data stands only in the cycle after the strobe
    nxt.rdata = reg_rd ? vpt_rd(q, reg_addr, stroke_in) : 16'h0000;
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      q <= '0;
      q.tol <= `VPT_TOL_RST;
    end else begin
      q <= nxt;
    end
  end

  // Outputs, all from flops
  assign pos1_feedback_out = q.fb[0];
  assign pos2_feedback_out = q.fb[1];
  assign pos3_feedback_out = q.fb[2];
  assign ext_switch1_out = q.ext1_out;
  assign led_pos = q.led_pos;
  assign led_fault = q.led_fault;
  assign fb_data_out = q.fb_dout;
  assign valve_drive = q.valve;
  assign reg_rdata = q.rdata;
  assign irq = q.irq;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (sys_rst);

  property p_range;
    (stroke_in > 16'(`VPT_STROKE_MAX_LSB)) |=> !q.in_range;
  endproperty
  a_range: assert property (p_range) else $error("stroke above range not rejected");

  property p_dark_out;
    (!q.ext_mode && !q.in_range) |-> (q.fb == 3'h0) ##1 (q.st != VPT_ST_IDLE || led_pos == 3'h0);
  endproperty
  a_dark_out: assert property (p_dark_out) else $error("output lit outside range");

  property p_teach_store;
    (q.st == VPT_ST_IDLE && teach_fire[0] && !clr_fire && !q.ext_mode && !reg_wr
     && stroke_in <= 16'(`VPT_STROKE_MAX_LSB))
      |=> q.taught[0] && q.pos[0] == $past(stroke_in) && q.st == VPT_ST_FLASH;
  endproperty
  a_teach_store: assert property (p_teach_store) else $error("teach did not store");

  property p_flash_end;
    (q.st == VPT_ST_FLASH && q.hcnt == 3'h5 && fast_wrap) |=> q.st == VPT_ST_IDLE;
  endproperty
  a_flash_end: assert property (p_flash_end) else $error("flash count wrong");

  property p_fault_teach;
    (q.st == VPT_ST_IDLE && (|teach_fire) && !clr_fire && !q.ext_mode
     && stroke_in > 16'(`VPT_STROKE_MAX_LSB)) |=> q.tfault ##1 led_fault[2];
  endproperty
  a_fault_teach: assert property (p_fault_teach) else $error("fault flash missing");

  property p_steady;
    (q.st == VPT_ST_IDLE && !q.ext_mode && q.in_range && q.fb[0]) |=> led_pos[0];
  endproperty
  a_steady: assert property (p_steady) else $error("LED 1 not steady");

  property p_mid_blink;
    (q.st == VPT_ST_IDLE && !q.ext_mode && q.in_range && q.fb[2]) |=> led_pos[2] == $past(q.slow_ph);
  endproperty
  a_mid_blink: assert property (p_mid_blink) else $error("LED 3 not blinking");

  property p_host_pos;
    (reg_wr && reg_addr == `VPT_A_POS2) |=> q.taught[1] && q.pos[1] == $past(reg_wdata);
  endproperty
  a_host_pos: assert property (p_host_pos) else $error("host position lost");

  property p_relay;
    ext_s[0] |=> ext_switch1_out && fb_data_out[0];
  endproperty
  a_relay: assert property (p_relay) else $error("initiator 1 not relayed");

  property p_variant;
    (q.ext_mode && !reg_wr) |=> $stable(q.taught) && pos2_feedback_out == $past(ext_s[1]);
  endproperty
  a_variant: assert property (p_variant) else $error("variant still teaches");

  property p_word;
    1'b1 |=> valve_drive == $past(fb_data_in[2:0]) && fb_data_out[3:2] == 2'b00;
  endproperty
  a_word: assert property (p_word) else $error("data word mapping wrong");

  property p_clear;
    (q.st == VPT_ST_IDLE && clr_fire && !q.ext_mode && !reg_wr) |=> q.taught == 3'h0;
  endproperty
  a_clear: assert property (p_clear) else $error("clear combo failed");

  property p_no_early;
    teach_fire[1] |-> $past(teach_req[1], 1) && $past(teach_req[1], 2);
  endproperty
  a_no_early: assert property (p_no_early) else $error("teach without hold");

  c_teach: cover property (q.st == VPT_ST_FLASH && !q.tfault ##1 q.st == VPT_ST_IDLE);
  c_fault: cover property (q.st == VPT_ST_FLASH && q.tfault);
  c_clear: cover property (q.st == VPT_ST_CLR);
  c_irq: cover property (irq);

endmodule : vpt_teach_fb

// ### dv/vpt_fb_master.sv
// Fieldbus master model: drives the valve bits and reads back the initiator bits
module vpt_fb_master (
  input wire logic core_clk, // Core clock
  input wire logic sys_rst, // Async reset, active high
  input wire logic [2:0] valve_cmd, // Valve request from the bench
  output logic [3:0] fb_data_in, // Data word to the block
  input wire logic [3:0] fb_data_out, // Data word from the block
  output logic [1:0] init_seen // Latest initiator bits
);
  timeunit 1ns;
  timeprecision 1ps;
  // --------------------------------------------------------------
  // Bus cycle
  // --------------------------------------------------------------
  // Unused bit 3 toggles every cycle, so any use of it shows up
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      fb_data_in <= 4'h0;
      init_seen <= 2'h0;
    end else begin
      fb_data_in <= {~fb_data_in[3], valve_cmd};
      init_seen <= fb_data_out[1:0];
    end
  end
endmodule : vpt_fb_master

// ### dv/tb_top.sv
// Self-checking testbench of the valve position teach and feedback block
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import vpt_pkg::*;
  logic core_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic [15:0] stroke_in = 16'h0000;
  logic [2:0] btn = 3'h0;
  logic [1:0] ext_in = 2'h0;
  logic [2:0] valve_cmd = 3'h0;
  logic [3:0] reg_addr = 4'h0;
  logic [15:0] reg_wdata = 16'h0000;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  wire logic [2:0] fb;
  logic ext1_out;
  logic irq;
  logic [2:0] led_pos;
  logic [2:0] led_fault;
  logic [2:0] valve_drive;
  logic [3:0] fb_data_in;
  logic [3:0] fb_data_out;
  logic [15:0] reg_rdata;
  logic [1:0] init_seen;
  int failures = 0;
  int n_tests = 0;

  // --------------------------------------------------------------
  // Clock, block and partner
  // --------------------------------------------------------------
  // Short hold and blink counts keep the run small
  always #2.5 core_clk = ~core_clk;

  vpt_teach_fb #(.TEACH_HOLD_CYC(32'h0000_0014), .RESET_HOLD_CYC(32'h0000_001E),
    .FAST_HALF_CYC(32'h0000_0004), .SLOW_HALF_CYC(32'h0000_0008)) dut_u (
    .core_clk(core_clk), .sys_rst(sys_rst), .stroke_in(stroke_in),
    .teach_btn_lower(btn[0]), .teach_btn_upper(btn[1]), .teach_btn_middle(btn[2]),
    .ext_switch1_in(ext_in[0]), .ext_switch2_in(ext_in[1]),
    .pos1_feedback_out(fb[0]), .pos2_feedback_out(fb[1]), .pos3_feedback_out(fb[2]),
    .ext_switch1_out(ext1_out), .led_pos(led_pos), .led_fault(led_fault),
    .fb_data_in(fb_data_in), .fb_data_out(fb_data_out), .valve_drive(valve_drive),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .irq(irq));

  vpt_fb_master master_u (.core_clk(core_clk), .sys_rst(sys_rst), .valve_cmd(valve_cmd),
    .fb_data_in(fb_data_in), .fb_data_out(fb_data_out), .init_seen(init_seen));

  // --------------------------------------------------------------
  // Shared tasks
  // --------------------------------------------------------------
  task automatic final_report();
    $display("Checks %0d, mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : final_report

  task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
    n_tests++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk);
  endtask : cyc

  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge core_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask : wr

  // Read data stand only in the cycle after the strobe
  task automatic rd(input string nm, input logic [3:0] a, input logic [15:0] mask,
                    input logic [15:0] exp);
    @(posedge core_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1;
    chk(nm, exp, reg_rdata & mask);
  endtask : rd

  task automatic set_stroke(input logic [15:0] v);
    @(posedge core_clk);
    stroke_in <= v;
  endtask : set_stroke

  task automatic press(input logic [2:0] m, input int n);
    @(posedge core_clk);
    btn <= m;
    cyc(n);
    btn <= 3'h0;
  endtask : press

  function automatic logic sel_sig(input int s);
    case (s)
      0: return led_pos[0];
      1: return led_pos[1];
      2: return led_pos[2];
      default: return led_fault[2];
    endcase
  endfunction : sel_sig

  // Bounded wait for an LED to light; a hang ends the run
  task automatic wait_hi(input int s, input string nm);
    int i;
    // Look 1 ns after the edge, where the LEDs have settled
    #1;
    for (i = 0; i < 400 && sel_sig(s) !== 1'b1; i++) begin
      @(posedge core_clk);
      #1;
    end
    if (i == 400) begin
      failures++;
      $display("[ERR] %s expected 1 seen timeout", nm);
      final_report();
    end
  endtask : wait_hi

  // Count rising edges of one LED over n cycles; a lit start is not a rise
  task automatic rises(input int s, input int n, output int k);
    logic prev;
    k = 0;
    #1;
    prev = sel_sig(s);
    repeat (n) begin
      @(posedge core_clk);
      #1;
      if (sel_sig(s) === 1'b1 && prev !== 1'b1) k++;
      prev = sel_sig(s);
    end
  endtask : rises

  // --------------------------------------------------------------
  // Scenarios
  // --------------------------------------------------------------
  task automatic t_reset();
    rd("tol", 4'h4, 16'hFFFF, 16'h0032);
    rd("stat", 4'h6, 16'hFFFF, 16'h0040);
    rd("unmapped", 4'hF, 16'hFFFF, 16'h0000);
    rd("clr_wo", 4'h9, 16'hFFFF, 16'h0000);
  endtask : t_reset

  task automatic t_host();
    set_stroke(16'h03E8);
    wr(4'h1, 16'h03E8);
    wr(4'h2, 16'h1388);
    cyc(4);
    chk("fb_host", 16'h0001, {13'h0, fb});
    chk("led_steady", 16'h0001, {13'h0, led_pos});
    rd("pos2_host", 4'h2, 16'hFFFF, 16'h1388);
    set_stroke(16'h041A);
    cyc(4);
    chk("fb_tol_edge", 16'h0001, {13'h0, fb});
    set_stroke(16'h041B);
    cyc(4);
    chk("fb_off_pos", 16'h0000, {13'h0, fb});
  endtask : t_host

  task automatic t_teach_any();
    logic acc;
    acc = 1'b1;
    wr(4'h8, 16'h0001);
    set_stroke(16'h0064);
    press(3'b010, 25);
    wait_hi(1, "led2_teach");
    rd("pos2", 4'h2, 16'hFFFF, 16'h0064);
    chk("irq_taught", 16'h0001, {15'h0, irq});
    wr(4'h9, 16'h0001);
    cyc(2);
    chk("irq_clear", 16'h0000, {15'h0, irq});
    cyc(40);
    repeat (16) begin
      acc = acc & led_pos[1];
      @(posedge core_clk);
    end
    chk("led2_steady", 16'h0001, {15'h0, acc});
    chk("fb2", 16'h0002, {13'h0, fb});
  endtask : t_teach_any

  task automatic t_flash3();
    int k;
    set_stroke(16'h1B58);
    // Released before the LED lights, so the wait sees the first flash
    press(3'b001, 21);
    wait_hi(0, "led1_teach");
    // Move away at an edge so no steady light follows the flashes
    @(posedge core_clk);
    stroke_in <= 16'h0000;
    rises(0, 60, k);
    // The first flash was already seen by the wait
    chk("fast_flashes", 16'h0003, k[15:0] + 16'h0001);
    rd("pos1", 4'h1, 16'hFFFF, 16'h1B58);
  endtask : t_flash3

  task automatic t_early();
    press(3'b100, 10);
    cyc(40);
    rd("pos3_kept", 4'h3, 16'hFFFF, 16'h0000);
    rd("taught3", 4'h6, 16'h0004, 16'h0000);
  endtask : t_early

  task automatic t_middle();
    int k;
    set_stroke(16'h07D0);
    press(3'b100, 25);
    wait_hi(2, "led3_teach");
    cyc(40);
    rises(2, 40, k);
    chk("led3_blinks", 16'h0001, {15'h0, k >= 2});
    chk("fb3", 16'h0004, {13'h0, fb});
  endtask : t_middle

  task automatic t_range();
    wr(4'h1, 16'h1F40);
    set_stroke(16'h1F40);
    cyc(4);
    chk("fb_at_top", 16'h0001, {15'h0, fb[0]});
    set_stroke(16'h1F41);
    cyc(4);
    chk("fb_beyond", 16'h0000, {13'h0, fb});
    wr(4'h8, 16'h0002);
    set_stroke(16'h2328);
    cyc(4);
    chk("leds_off", 16'h0000, {10'h0, led_pos, led_fault});
    press(3'b100, 25);
    wait_hi(3, "led3_fault");
    chk("irq_fault", 16'h0001, {15'h0, irq});
    rd("pos3_same", 4'h3, 16'hFFFF, 16'h07D0);
    cyc(40);
    wr(4'h9, 16'h000F);
  endtask : t_range

  task automatic t_clear();
    set_stroke(16'h0064);
    press(3'b011, 40);
    cyc(40);
    rd("untaught", 4'h6, 16'h0007, 16'h0000);
    rd("irq_reset", 4'h7, 16'hFFFF, 16'h0004);
  endtask : t_clear

  task automatic t_variant();
    wr(4'h0, 16'h0001);
    ext_in <= 2'b01;
    cyc(6);
    chk("ini1_fb", 16'h0011, {9'h0, led_pos, 1'b0, fb});
    chk("ini1_word", 16'h0001, {14'h0, init_seen});
    chk("ext1_relay", 16'h0001, {15'h0, ext1_out});
    ext_in <= 2'b10;
    cyc(6);
    chk("ini2_fb", 16'h0022, {9'h0, led_pos, 1'b0, fb});
    chk("ini2_word", 16'h0002, {14'h0, init_seen});
    valve_cmd <= 3'b101;
    cyc(3);
    chk("valves", 16'h0005, {13'h0, valve_drive});
    press(3'b100, 25);
    cyc(10);
    rd("no_teach", 4'h6, 16'h0007, 16'h0000);
  endtask : t_variant

  // --------------------------------------------------------------
  // Main sequence
  // --------------------------------------------------------------
  initial begin
    cyc(4);
    sys_rst <= 1'b0;
    cyc(2);
    t_reset();
    t_host();
    t_teach_any();
    t_flash3();
    t_early();
    t_middle();
    t_range();
    t_clear();
    t_variant();
    final_report();
  end
endmodule : tb_top
